// ==== rtl/hbq_dev_end.sv ====
`timescale 1ns/100ps
module hbq_dev_end
  import hbq_pkg::*;
#(
  parameter int TXQ_BYTES = TXQ_BYTES_DEF,
  parameter int RXQ_BYTES = RXQ_BYTES_DEF
) (
  input  wire logic clk,              // 100 MHz clock
  input  wire logic srst,             // Synchronous reset
  hbq_bus_if.dev    bus,              // Host bus pins
  input  wire logic byte_order_strap, // High selects big endian
  input  wire logic bus_width_strap,  // High selects 16-bit bus
  output logic [7:0] mac_data,        // Frame byte to MAC
  output logic      mac_valid,        // Byte valid
  output logic      mac_last,         // Last byte of frame
  output logic      mac_crc_append,   // MAC appends checksum
  output logic      tx_irq            // Completion interrupt pulse
);
  localparam int PW = $clog2(TXQ_BYTES);
  localparam int SW = 30;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CW0, ST_CW1, ST_BC0, ST_BC1, ST_DATA, ST_END
  } hbq_tx_e;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [SW-1:0] pin_in;
  logic [SW-1:0] p1_r;
  logic [SW-1:0] p2_r;
  logic          rd_prev_r;
  logic          wr_prev_r;

  assign pin_in = {bus.read_strobe_n, bus.write_strobe_n, bus.addr_qualify_n, bus.addr,
                   bus.lane0_enable_n, bus.lane1_enable_n, bus.data,
                   byte_order_strap, bus_width_strap};

  // Two flops on every pin input
  always_ff @(posedge clk) begin
    p1_r      <= pin_in;
    p2_r      <= p1_r;
    rd_prev_r <= srst ? 1'b1 : p2_r[29];
    wr_prev_r <= srst ? 1'b1 : p2_r[28];
  end

  wire        rd_n_s   = p2_r[29];
  wire        wr_n_s   = p2_r[28];
  wire        qual_n_s = p2_r[27];
  wire [7:1]  addr_s   = p2_r[26:20];
  wire        be0_n_s  = p2_r[19];
  wire        be1_n_s  = p2_r[18];
  wire [15:0] d_s      = p2_r[17:2];
  wire        be_strap = p2_r[1];
  wire        wide16   = p2_r[0];

  //////////////////////////////////////////////////////////////////////////////
  // Decode and lane steering
  logic [15:0] tx_ctrl_r;
  logic [15:0] rx_dptr_r;
  logic [15:0] tx_stat_r;
  logic [15:0] dout_r;
  logic        doe_r;
  logic        ready_r;
  logic [7:0]  mem [TXQ_BYTES];
  logic [PW-1:0] wptr_r;
  logic [PW-1:0] rptr_r;
  logic [PW-1:0] cend_r;

  // Combinational select from raw pins
  assign bus.device_selected_n = bus.addr_qualify_n | (bus.addr[7:4] < SEL_LOW_NIB);

  wire [7:0] off      = {addr_s, 1'b0};
  wire       hit      = ~qual_n_s & (addr_s[7:4] >= SEL_LOW_NIB);
  wire       rd_fall  = rd_prev_r & ~rd_n_s & hit;
  wire       rd_rise  = ~rd_prev_r & rd_n_s;
  wire       wr_fall  = wr_prev_r & ~wr_n_s & hit;
  wire       be1_eff  = wide16 ? be1_n_s : ~be0_n_s;
  wire       lane0    = ~be0_n_s;
  wire       lane1    = ~be1_eff;
  wire       two_b    = lane0 & lane1;
  wire [7:0] fbyte    = (lane0 | ~wide16) ? d_s[7:0] : d_s[15:8];
  wire [7:0] sbyte    = d_s[15:8];
  wire       big_end  = be_strap | rx_dptr_r[ENDIAN_BIT];
  wire [15:0] wmask   = {{8{lane1}}, {8{lane0}}};
  wire [15:0] wval    = wide16 ? d_s : {d_s[7:0], d_s[7:0]};
  wire        q_wr    = wr_fall & (off == REG_TXQ_DATA) & (lane0 | lane1);
  wire        q_enq   = wr_fall & (off == REG_TXQ_CMD) & d_s[ENQ_BIT];

  function automatic logic [PW-1:0] ptr_add(input logic [PW-1:0] p, input logic [1:0] n);
    logic [PW:0] s;
    s = {1'b0, p} + {{(PW-1){1'b0}}, n};
    if (s >= (PW+1)'(TXQ_BYTES)) begin
      s = s - (PW+1)'(TXQ_BYTES);
    end
    return s[PW-1:0];
  endfunction : ptr_add

  wire [PW-1:0] used  = (wptr_r >= rptr_r) ? wptr_r - rptr_r
                                           : PW'(TXQ_BYTES) - rptr_r + wptr_r;
  wire [15:0] free_b  = 16'(TXQ_BYTES) - 16'(used);
  wire [15:0] rd_mux  = (off == REG_TX_CTRL) ? tx_ctrl_r :
                        (off == REG_TX_STAT) ? tx_stat_r :
                        (off == REG_TX_FREE) ? free_b :
                        (off == REG_RX_DPTR) ? rx_dptr_r : 16'h0000;
  // 8-bit mode returns the selected lane on the low byte
  wire [15:0] rd_out  = (!wide16 && be0_n_s) ? {8'h00, rd_mux[15:8]} : rd_mux;

  //////////////////////////////////////////////////////////////////////////////
  // Register writes, read drive and ready
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_ctrl_r <= TX_CTRL_RST;
      rx_dptr_r <= RX_DPTR_RST;
      dout_r    <= 16'h0000;
      doe_r     <= 1'b0;
      ready_r   <= 1'b1;
    end else begin
      if (wr_fall && off == REG_TX_CTRL) begin
        tx_ctrl_r <= (tx_ctrl_r & ~wmask) | (wval & wmask);
      end
      if (wr_fall && off == REG_RX_DPTR) begin
        rx_dptr_r <= (rx_dptr_r & ~wmask) | (wval & wmask);
      end
      if (rd_fall) begin
        dout_r <= rd_out;
        doe_r  <= 1'b1;
      end else if (rd_rise) begin
        doe_r  <= 1'b0;
      end
      ready_r <= ~(rd_fall | wr_fall);
    end
  end

  assign bus.dev_dout   = dout_r;
  assign bus.dev_doe    = doe_r;
  assign bus.wait_ready = ready_r;

  // Queue byte writes through the data port
  always_ff @(posedge clk) begin
    if (q_wr) begin
      mem[wptr_r] <= fbyte;
      if (two_b) begin
        mem[ptr_add(wptr_r, 2'd1)] <= sbyte;
      end
    end
  end

  // Write pointer; enqueue commits frames rounded to a word
  always_ff @(posedge clk) begin
    if (srst) begin
      wptr_r <= '0;
      cend_r <= '0;
    end else if (q_wr) begin
      wptr_r <= ptr_add(wptr_r, two_b ? 2'd2 : 2'd1);
    end else if (q_enq) begin
      wptr_r <= ptr_add(wptr_r, {1'b0, wptr_r[0]});
      cend_r <= ptr_add(wptr_r, {1'b0, wptr_r[0]});
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit engine
  hbq_tx_e          st_r;
  logic [7:0]       b0_r;
  logic [15:0]      cw_r;
  logic [LEN_W-1:0] rem_r;
  wire  [7:0]       qbyte = mem[rptr_r];
  wire  [15:0]      hword = big_end ? {b0_r, qbyte} : {qbyte, b0_r};

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r           <= ST_IDLE;
      rptr_r         <= '0;
      b0_r           <= 8'h00;
      cw_r           <= 16'h0000;
      rem_r          <= '0;
      tx_stat_r      <= TX_STAT_RST;
      mac_data       <= 8'h00;
      mac_valid      <= 1'b0;
      mac_last       <= 1'b0;
      mac_crc_append <= 1'b0;
      tx_irq         <= 1'b0;
    end else begin
      mac_valid <= 1'b0;
      mac_last  <= 1'b0;
      tx_irq    <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (rptr_r != cend_r) begin
            st_r <= ST_CW0;
          end
        end
        ST_CW0, ST_BC0: begin
          b0_r   <= qbyte;
          rptr_r <= ptr_add(rptr_r, 2'd1);
          st_r   <= (st_r == ST_CW0) ? ST_CW1 : ST_BC1;
        end
        ST_CW1: begin
          cw_r   <= hword;
          rptr_r <= ptr_add(rptr_r, 2'd1);
          st_r   <= ST_BC0;
        end
        ST_BC1: begin
          rem_r  <= hword[LEN_W-1:0];
          rptr_r <= ptr_add(rptr_r, 2'd1);
          st_r   <= ST_DATA;
          // Status tracks the frame now handed to the MAC
          tx_stat_r <= {1'b0, 1'b1, 8'h00, cw_r[ID_W-1:0]};
          mac_crc_append <= tx_ctrl_r[CRC_EN_BIT];
        end
        ST_DATA: begin
          mac_data  <= qbyte;
          mac_valid <= 1'b1;
          mac_last  <= (rem_r == LEN_W'(1));
          rptr_r    <= ptr_add(rptr_r, 2'd1);
          rem_r     <= rem_r - LEN_W'(1);
          if (rem_r == LEN_W'(1)) begin
            st_r <= ST_END;
          end
        end
        ST_END: begin
          rptr_r <= ptr_add(rptr_r, {1'b0, rptr_r[0]});
          tx_stat_r[STAT_DONE_BIT] <= 1'b1;
          tx_stat_r[STAT_BUSY_BIT] <= 1'b0;
          tx_irq <= cw_r[IRQ_ON_CMPL];
          st_r   <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
endmodule : hbq_dev_end

// ==== rtl/hbq_pkg.sv ====
package hbq_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0]  REG_TX_CTRL   = 8'h70;
  localparam logic [7:0]  REG_TX_STAT   = 8'h72;
  localparam logic [7:0]  REG_TX_FREE   = 8'h78;
  localparam logic [7:0]  REG_TXQ_CMD   = 8'h80;
  localparam logic [7:0]  REG_RX_DPTR   = 8'h86;
  localparam logic [7:0]  REG_TXQ_DATA  = 8'h88;
  // Device answers from this upper address nibble upward
  localparam logic [3:0]  SEL_LOW_NIB   = 4'h7;
  // Field positions and widths
  localparam int          CRC_EN_BIT    = 1;
  localparam int          ENQ_BIT       = 0;
  localparam int          ENDIAN_BIT    = 11;
  localparam int          IRQ_ON_CMPL   = 15;
  localparam int          ID_W          = 6;
  localparam int          LEN_W         = 11;
  localparam int          STAT_DONE_BIT = 15;
  localparam int          STAT_BUSY_BIT = 14;
  // Reset values
  localparam logic [15:0] TX_CTRL_RST   = 16'h0000;
  localparam logic [15:0] RX_DPTR_RST   = 16'h0000;
  localparam logic [15:0] TX_STAT_RST   = 16'h0000;
  // Queue sizes and payload limit in bytes, synchroniser depth
  localparam int          TXQ_BYTES_DEF = 6144;
  localparam int          RXQ_BYTES_DEF = 12288;
  localparam int          MAX_PAYLOAD   = 2000;
  localparam int          SYNC_STAGES   = 2;
endpackage : hbq_pkg

// ==== rtl/hbq_bus_if.sv ====
`timescale 1ns/100ps
interface hbq_bus_if;
  logic [7:1]  addr;             // Address pins
  logic        addr_qualify_n;   // Address qualify, low enables decode
  logic        read_strobe_n;    // Read strobe
  logic        write_strobe_n;   // Write strobe
  logic        lane0_enable_n;   // Byte lane 0 enable
  logic        lane1_enable_n;   // Byte lane 1 enable
  logic [15:0] host_dout;        // Host data drive
  logic        host_doe;         // Host drives data
  logic [15:0] dev_dout;         // Device data drive
  logic        dev_doe;          // Device drives data
  logic        wait_ready;       // Low asks host for wait states
  logic        device_selected_n;// Device is targeted
  logic [15:0] data;             // Resolved data wire

  // Resolve the shared data bus from the enables
  assign data = dev_doe ? dev_dout : (host_doe ? host_dout : 16'h0000);

  modport dev  (input  addr, addr_qualify_n, read_strobe_n, write_strobe_n,
                       lane0_enable_n, lane1_enable_n, data,
                output dev_dout, dev_doe, wait_ready, device_selected_n);
  modport host (input  data, wait_ready, device_selected_n,
                output addr, addr_qualify_n, read_strobe_n, write_strobe_n,
                       lane0_enable_n, lane1_enable_n, host_dout, host_doe);
endinterface : hbq_bus_if

// ==== rtl/hbq_host_end.sv ====
`timescale 1ns/100ps
module hbq_host_end
  import hbq_pkg::*;
(
  input  wire logic        clk,       // 100 MHz clock
  input  wire logic        srst,      // Synchronous reset
  hbq_bus_if.host          bus,       // Device bus pins
  input  wire logic [7:0]  cmd_addr,  // Byte offset
  input  wire logic [15:0] cmd_wdata, // Write data
  input  wire logic [1:0]  cmd_be,    // Lane enables, active high
  input  wire logic        cmd_wr,    // Write request pulse
  input  wire logic        cmd_rd,    // Read request pulse
  output logic [15:0]      cmd_rdata, // Read data
  output logic             cmd_busy,  // Access in progress
  output logic             cmd_done   // Access finished pulse
);
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_STROBE, H_WAITLO, H_WAITHI, H_END} hbq_h_e;

  hbq_h_e      st_r;
  logic        rdy1_r, rdy2_r;
  logic [15:0] d1_r, d2_r;
  logic        is_rd_r;
  logic [7:1]  addr_r;
  logic        qual_n_r, rd_n_r, wr_n_r, be0_n_r, be1_n_r, doe_r;
  logic [15:0] dout_r;

  //////////////////////////////////////////////////////////////////////////////
  // Synchronise ready and data
  always_ff @(posedge clk) begin
    rdy1_r <= bus.wait_ready;
    rdy2_r <= rdy1_r;
    d1_r   <= bus.data;
    d2_r   <= d1_r;
  end

  assign bus.addr           = addr_r;
  assign bus.addr_qualify_n = qual_n_r;
  assign bus.read_strobe_n  = rd_n_r;
  assign bus.write_strobe_n = wr_n_r;
  assign bus.lane0_enable_n = be0_n_r;
  assign bus.lane1_enable_n = be1_n_r;
  assign bus.host_dout      = dout_r;
  assign bus.host_doe       = doe_r;

  //////////////////////////////////////////////////////////////////////////////
  // Access sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r      <= H_IDLE;
      addr_r    <= 7'h00;
      qual_n_r  <= 1'b1;
      rd_n_r    <= 1'b1;
      wr_n_r    <= 1'b1;
      be0_n_r   <= 1'b1;
      be1_n_r   <= 1'b1;
      dout_r    <= 16'h0000;
      doe_r     <= 1'b0;
      is_rd_r   <= 1'b0;
      cmd_rdata <= 16'h0000;
      cmd_busy  <= 1'b0;
      cmd_done  <= 1'b0;
    end else begin
      cmd_done <= 1'b0;
      case (st_r)
        H_IDLE: begin
          if (cmd_wr || cmd_rd) begin
            addr_r   <= cmd_addr[7:1];
            qual_n_r <= 1'b0;
            be0_n_r  <= ~cmd_be[0];
            be1_n_r  <= ~cmd_be[1];
            dout_r   <= cmd_wdata;
            doe_r    <= cmd_wr;
            is_rd_r  <= cmd_rd;
            cmd_busy <= 1'b1;
            st_r     <= H_SETUP;
          end
        end
        H_SETUP: begin
          rd_n_r <= ~is_rd_r;
          wr_n_r <= is_rd_r;
          st_r   <= H_STROBE;
        end
        H_STROBE: st_r <= H_WAITLO;
        H_WAITLO: begin
          if (!rdy2_r) begin
            st_r <= H_WAITHI;
          end
        end
        H_WAITHI: begin
          // Strobe held until ready returns
          if (rdy2_r) begin
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            if (is_rd_r) begin
              cmd_rdata <= d2_r;
            end
            st_r <= H_END;
          end
        end
        H_END: begin
          qual_n_r <= 1'b1;
          be0_n_r  <= 1'b1;
          be1_n_r  <= 1'b1;
          doe_r    <= 1'b0;
          cmd_busy <= 1'b0;
          cmd_done <= 1'b1;
          st_r     <= H_IDLE;
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end
endmodule : hbq_host_end

// ==== tb/hbq_bus_properties.sv ====
`timescale 1ns/100ps
module hbq_bus_properties
  import hbq_pkg::*;
(
  input wire logic       clk,               // Clock
  input wire logic       srst,              // Synchronous reset
  input wire logic [7:1] addr,              // Address pins
  input wire logic       addr_qualify_n,    // Decode enable
  input wire logic       read_strobe_n,     // Read strobe
  input wire logic       write_strobe_n,    // Write strobe
  input wire logic       host_doe,          // Host drives data
  input wire logic       dev_doe,           // Device drives data
  input wire logic       wait_ready,        // Low asks for wait
  input wire logic       device_selected_n  // Device targeted
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////
  // Decode and ready handshake
  sel_decode_a: assert property (
    device_selected_n == !(!addr_qualify_n && addr[7:4] >= SEL_LOW_NIB))
    else $error("Select decode wrong");
  ready_answer_a: assert property (
    $fell(read_strobe_n && write_strobe_n) && !device_selected_n |-> ##[2:8] !wait_ready)
    else $error("No wait pulse after strobe fall");
  ready_pulse_a: assert property ($fell(wait_ready) |=> wait_ready)
    else $error("Wait pulse longer than one cycle");
  ready_in_cycle_a: assert property (
    !wait_ready |-> !(read_strobe_n && write_strobe_n) && !device_selected_n)
    else $error("Wait pulse outside an access");
  host_hold_a: assert property (
    !wait_ready |=> !(read_strobe_n && write_strobe_n) && $stable(addr))
    else $error("Host released access during wait");

  ////////////////////////////////////////////////////////////////////////////
  // Data bus ownership
  bus_owner_a: assert property (!(dev_doe && host_doe))
    else $error("Both ends drive data");
  strobe_excl_a: assert property (read_strobe_n || write_strobe_n)
    else $error("Both strobes low");
  read_data_a: assert property ($rose(read_strobe_n) |-> $past(dev_doe))
    else $error("Read data not driven at strobe rise");
  read_release_a: assert property ($rose(read_strobe_n) |-> ##[1:4] !dev_doe)
    else $error("Device kept data bus after read");
  write_setup_a: assert property (!write_strobe_n |-> host_doe && !dev_doe)
    else $error("Write data not driven by host");
endmodule : hbq_bus_properties

// ==== tb/tb.sv ====
`timescale 1ns/100ps
module tb;
  import hbq_pkg::*;
  localparam int TXQ_N = 64;
  logic        clk, srst, bo_strap, bw_strap, cmd_wr, cmd_rd, cmd_busy, cmd_done;
  logic        mac_valid, mac_last, mac_crc_append, tx_irq, crc_seen;
  logic [7:0]  cmd_addr, mac_data;
  logic [15:0] cmd_wdata, cmd_rdata;
  logic [1:0]  cmd_be;
  logic [7:0]  mac_q[$];
  int          fails, n_checks, cycles, irq_n, last_n;

  hbq_bus_if bif ();
  hbq_dev_end #(.TXQ_BYTES(TXQ_N), .RXQ_BYTES(RXQ_BYTES_DEF)) hbq_dev_end_i (
    .clk(clk), .srst(srst), .bus(bif), .byte_order_strap(bo_strap),
    .bus_width_strap(bw_strap), .mac_data(mac_data), .mac_valid(mac_valid),
    .mac_last(mac_last), .mac_crc_append(mac_crc_append), .tx_irq(tx_irq));
  hbq_host_end hbq_host_end_i (
    .clk(clk), .srst(srst), .bus(bif), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_be(cmd_be), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
    .cmd_busy(cmd_busy), .cmd_done(cmd_done));
  hbq_bus_properties hbq_bus_properties_i (
    .clk(clk), .srst(srst), .addr(bif.addr), .addr_qualify_n(bif.addr_qualify_n),
    .read_strobe_n(bif.read_strobe_n), .write_strobe_n(bif.write_strobe_n),
    .host_doe(bif.host_doe), .dev_doe(bif.dev_doe), .wait_ready(bif.wait_ready),
    .device_selected_n(bif.device_selected_n));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and MAC stream capture
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      $display("ERROR watchdog expected done seen hang");
      tally_and_finish();
    end
    if (mac_valid === 1'b1) begin
      mac_q.push_back(mac_data);
      if (mac_last === 1'b1) begin
        last_n++;
        crc_seen = mac_crc_append;
      end
    end
    if (tx_irq === 1'b1) irq_n++;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access tasks
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wait_done;
    int i;
    for (i = 0; i < 60; i++) begin
      @(posedge clk);
      if (cmd_done === 1'b1) break;
    end
    chk("cmd_done", 16'h0001, {15'h0000, i < 60});
    chk("cmd_busy", 16'h0000, {15'h0000, cmd_busy});
  endtask : wait_done
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
    @(posedge clk);
    cmd_addr  <= a;
    cmd_wdata <= d;
    cmd_be    <= be;
    cmd_wr    <= 1'b1;
    @(posedge clk);
    cmd_wr <= 1'b0;
    wait_done();
  endtask : wr
  task automatic rchk(input string nm, input logic [7:0] a, input logic [1:0] be,
                      input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
    @(posedge clk);
    cmd_addr <= a;
    cmd_be   <= be;
    cmd_rd   <= 1'b1;
    @(posedge clk);
    cmd_rd <= 1'b0;
    wait_done();
    chk(nm, e & m, cmd_rdata & m);
  endtask : rchk
  // Write one frame's header and data into the queue, control word first
  task automatic qdata(input logic [15:0] c, input logic [15:0] bc, input logic [15:0] w0,
                       input logic [15:0] w1, input int n);
    wr(REG_TXQ_DATA, c, 2'b11);
    wr(REG_TXQ_DATA, bc, 2'b11);
    wr(REG_TXQ_DATA, w0, 2'b11);
    if (n > 2) wr(REG_TXQ_DATA, w1, 2'b11);
  endtask : qdata
  // Queue one frame, enqueue it and compare what reaches the MAC
  task automatic frame(input logic [15:0] c, input logic [15:0] bc, input logic [15:0] w0,
                       input logic [15:0] w1, input int n, input logic [31:0] eb,
                       input logic ei, input logic ec, input logic [5:0] id);
    int i;
    mac_q.delete();
    irq_n  = 0;
    last_n = 0;
    qdata(c, bc, w0, w1, n);
    wr(REG_TXQ_CMD, 16'h0001, 2'b11);
    for (i = 0; i < 300 && last_n == 0; i++) @(posedge clk);
    repeat (6) @(posedge clk);
    chk("mac_count", 16'(n), 16'(mac_q.size()));
    for (i = 0; i < n; i++) chk("mac_byte", {8'h00, eb[8*i +: 8]}, {8'h00, mac_q[i]});
    chk("tx_irq", {15'h0000, ei}, 16'(irq_n));
    chk("crc_append", {15'h0000, ec}, {15'h0000, crc_seen});
    rchk("stat_id", REG_TX_STAT, 2'b11, {2'b10, 8'h00, id}, 16'hC03F);
  endtask : frame
  // Two frames under one enqueue leave the queue back to back
  task automatic pair;
    int i;
    mac_q.delete();
    irq_n  = 0;
    last_n = 0;
    qdata(16'h8001, 16'h0003, 16'h2010, 16'h0030, 3);
    qdata(16'h0002, 16'h0002, 16'h5040, 16'h0000, 2);
    wr(REG_TXQ_CMD, 16'h0001, 2'b11);
    for (i = 0; i < 300 && last_n < 2; i++) @(posedge clk);
    repeat (6) @(posedge clk);
    chk("pair_frames", 16'h0002, 16'(last_n));
    chk("pair_count", 16'h0005, 16'(mac_q.size()));
    for (i = 0; i < 5; i++) begin
      chk("pair_byte", 16'(16 * i + 16), {8'h00, mac_q[i]});
    end
    chk("pair_irq", 16'h0001, 16'(irq_n));
    rchk("pair_stat", REG_TX_STAT, 2'b11, 16'h8002, 16'hC03F);
  endtask : pair
  task automatic tally_and_finish;
    $display("Checks %0d, fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {srst, bo_strap, bw_strap, cmd_wr, cmd_rd} = 5'b10100;
    {cmd_addr, cmd_wdata, cmd_be} = '0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rchk("tx_ctrl_rst", REG_TX_CTRL, 2'b11, TX_CTRL_RST);
    rchk("tx_stat_rst", REG_TX_STAT, 2'b11, TX_STAT_RST);
    rchk("rx_dptr_rst", REG_RX_DPTR, 2'b11, RX_DPTR_RST);
    rchk("tx_free_rst", REG_TX_FREE, 2'b11, 16'(TXQ_N));
    rchk("unmapped", 8'h7E, 2'b11, 16'h0000);
    wr(REG_TX_STAT, 16'hFFFF, 2'b11);
    rchk("tx_stat_ro", REG_TX_STAT, 2'b11, TX_STAT_RST);
    wr(REG_TX_CTRL, 16'h0002, 2'b11);
    wr(REG_TX_CTRL, 16'hAB55, 2'b10);
    rchk("tx_ctrl_lane", REG_TX_CTRL, 2'b11, 16'hAB02);
    bw_strap <= 1'b0;
    repeat (4) @(posedge clk);
    rchk("byte_lo", REG_TX_CTRL, 2'b01, 16'h0002, 16'h00FF);
    rchk("byte_hi", REG_TX_CTRL, 2'b10, 16'h00AB, 16'h00FF);
    wr(REG_TX_CTRL, 16'h00CD, 2'b10);
    bw_strap <= 1'b1;
    repeat (4) @(posedge clk);
    rchk("width16", REG_TX_CTRL, 2'b11, 16'hCD02);
    frame(16'h8015, 16'h0004, 16'h2211, 16'h4433, 4, 32'h4433_2211, 1, 1, 6'h15);
    pair();
    wr(REG_TX_CTRL, 16'h0000, 2'b11);
    wr(REG_RX_DPTR, 16'h0800, 2'b11);
    frame(16'h0700, 16'h0300, 16'hBBAA, 16'h00CC, 3, 32'h00CC_BBAA, 0, 0, 6'h07);
    wr(REG_RX_DPTR, 16'h0000, 2'b11);
    bo_strap <= 1'b1;
    repeat (4) @(posedge clk);
    frame(16'h3F80, 16'h0200, 16'h5AA5, 16'h0000, 2, 32'h0000_5AA5, 1, 0, 6'h3F);
    tally_and_finish();
  end
endmodule : tb
